/* sbi_engine.sv */
// Serial bus index sequencer with event mask and interrupt status
`include "sbi_regs.svh"

module sbi_engine
  import sbi_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [19:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  // Command fields from the rest of the engine
  input  wire logic        cmd_go_in,
  input  wire logic        cmd_read_in,
  input  wire logic        cmd_index_en_in,
  input  wire logic [7:0]  cmd_index_in,
  input  wire logic        cmd_no_stop_in,
  input  wire logic [8:0]  cmd_byte_count_in,
  input  wire logic        software_clear_interrupt_in,
  // Data buffer
  input  wire logic        data_wr_in,
  input  wire logic [31:0] data_wdata_in,
  output logic             data_wready_out,
  input  wire logic        data_rd_in,
  output logic      [31:0] data_rdata_out,
  // Link pins
  input  wire logic        link_clk_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // Status
  output logic             hardware_ready_flag_out,
  output logic             hold_phase_flag_out,
  output logic             nak_flag_out,
  output logic             stall_flag_out,
  output logic             active_out,
  output logic             irq_status_out
);

  // Synchronised link inputs
  logic [1:0]  pins_s;
  wire         link_clk_s;
  wire         sda_s;
  logic        link_clk_d_r;
  wire         link_edge;
  wire         link_fall;

  // Software-visible registers
  sbi_mask_t   mask_r;
  logic        idx_en_r;
  logic [15:0] idx_r;
  logic [31:0] rdata_r;

  // Sequencer state
  sbi_state_e  state_r;
  sbi_state_e  state_nxt;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  bit_cnt_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [8:0]  bytes_left_r;
  logic [8:0]  bytes_left_nxt;
  logic [1:0]  byte_sel_r;
  logic [1:0]  byte_sel_nxt;
  logic [7:0]  cmd_idx_r;
  logic [7:0]  cmd_idx_nxt;
  logic        rd_mode_r;
  logic        rd_mode_nxt;
  logic        no_stop_r;
  logic        no_stop_nxt;
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  logic        word_valid_r;
  logic        word_valid_nxt;
  logic        load_pend_r;
  logic        load_pend_nxt;
  logic [31:0] rword_r;
  logic [31:0] rword_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] data_rdata_r;
  logic [31:0] data_rdata_nxt;
  logic        sda_out_r;
  logic        sda_out_nxt;
  logic        sda_oe_r;
  logic        sda_oe_nxt;
  logic [`SBI_STALL_CNT_W-1:0] stall_cnt_r;
  logic [`SBI_STALL_CNT_W-1:0] stall_cnt_nxt;

  // Flags
  logic        nak_r;
  logic        stall_r;
  logic        irq_status_r;
  logic        hardware_ready_flag_d_r;
  logic        nak_set;
  logic        stall_set;

  // Decode and selection
  wire         sel_mask;
  wire         sel_idx;
  wire         busy;
  wire         tx_mode;
  wire         ack_slot;
  wire         last_byte;
  wire         word_end;
  wire         wait_data;
  wire [7:0]   lane_byte;
  wire [7:0]   idx_byte;
  wire [7:0]   tx_byte;
  wire         fifo_in_ready;
  wire         fifo_out_valid;
  wire         fifo_out_ready;
  wire [31:0]  fifo_out_data;
  wire         hardware_ready_flag;
  wire         idle_entry;
  wire         hold_entry;
  wire [4:0]   events;
  wire         irq_set;

  sbi_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in    (rst_in),
    .async_in  ({link_clk_in, sda_in}),
    .sync_out  (pins_s)
  );

  assign link_clk_s = pins_s[1];
  assign sda_s      = pins_s[0];
  assign link_edge  = link_clk_s && !link_clk_d_r;
  assign link_fall  = !link_clk_s && link_clk_d_r;

  sbi_fifo #(
    .WIDTH(`SBI_WORD_W),
    .DEPTH(`SBI_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .in_valid_in  (data_wr_in),
    .in_data_in   (data_wdata_in),
    .in_ready_out (fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_ready_in (fifo_out_ready),
    .out_data_out (fifo_out_data)
  );

  assign sel_mask  = (reg_addr_in == `SBI_IRQ_MASK_ADDR);
  assign sel_idx   = (reg_addr_in == `SBI_TWO_BYTE_IDX_ADDR);
  assign busy      = (state_r == SBI_IDX_HI) || (state_r == SBI_IDX_LO) ||
                     (state_r == SBI_DATA);
  assign tx_mode   = (state_r != SBI_DATA) || !rd_mode_r;
  assign ack_slot  = (bit_cnt_r == `SBI_ACK_SLOT);
  assign last_byte = (bytes_left_r == 9'h001);
  assign word_end  = (byte_sel_r == 2'h3) || last_byte;
  assign lane_byte = word_r[{byte_sel_r, 3'h0} +: 8];

  assign idx_byte  = (state_r == SBI_IDX_HI) ?
                     idx_r[`SBI_IDX_HI_MSB:`SBI_IDX_HI_LSB] :
                     (idx_en_r ? idx_r[`SBI_IDX_LO_MSB:0] : cmd_idx_r);
  assign tx_byte   = (state_r == SBI_DATA) ? lane_byte : idx_byte;

  // Byte start held while the word is missing or the read word is unread
  assign wait_data = (state_r == SBI_DATA) && (bit_cnt_r == 4'h0) &&
                     (rd_mode_r ? (rvalid_r && byte_sel_r == 2'h0)
                                : !word_valid_r);

  assign fifo_out_ready = (state_r == SBI_DATA) && !rd_mode_r &&
                          !word_valid_r && !load_pend_r;

  assign hardware_ready_flag = !busy ? 1'b1 : (rd_mode_r ? rvalid_r : fifo_in_ready);

  assign idle_entry = (state_r != SBI_IDLE) && (state_nxt == SBI_IDLE);
  assign hold_entry = (state_r != SBI_HOLD) && (state_nxt == SBI_HOLD);

  assign events[`SBI_MASK_STALL] = stall_set;
  assign events[`SBI_MASK_NAK]   = nak_set;
  assign events[`SBI_MASK_IDLE]  = idle_entry;
  assign events[`SBI_MASK_HOLD]  = hold_entry;
  assign events[`SBI_MASK_HARDWARE_READY_FLAG] = hardware_ready_flag && !hardware_ready_flag_d_r;

  assign irq_set = |(events & mask_r);

  always_comb begin
    state_nxt      = state_r;
    bit_cnt_nxt    = bit_cnt_r;
    shift_nxt      = shift_r;
    bytes_left_nxt = bytes_left_r;
    byte_sel_nxt   = byte_sel_r;
    cmd_idx_nxt    = cmd_idx_r;
    rd_mode_nxt    = rd_mode_r;
    no_stop_nxt    = no_stop_r;
    word_nxt       = word_r;
    word_valid_nxt = word_valid_r;
    load_pend_nxt  = 1'b0;
    rword_nxt      = rword_r;
    rvalid_nxt     = rvalid_r && !data_rd_in;
    data_rdata_nxt = data_rdata_r;
    sda_out_nxt    = sda_out_r;
    sda_oe_nxt     = sda_oe_r;
    stall_cnt_nxt  = '0;
    nak_set        = 1'b0;
    stall_set      = 1'b0;

    if (load_pend_r) begin
      word_nxt       = fifo_out_data;
      word_valid_nxt = 1'b1;
    end else if (fifo_out_ready && fifo_out_valid) begin
      load_pend_nxt = 1'b1;
    end

    case (state_r)
      SBI_IDLE, SBI_HOLD: begin
        sda_oe_nxt = 1'b0;
        if (cmd_go_in) begin
          rd_mode_nxt    = cmd_read_in;
          no_stop_nxt    = cmd_no_stop_in;
          bytes_left_nxt = cmd_byte_count_in;
          cmd_idx_nxt    = cmd_index_in;
          bit_cnt_nxt    = 4'h0;
          byte_sel_nxt   = 2'h0;
          word_valid_nxt = 1'b0;
          if (!cmd_index_en_in) begin
            state_nxt = (cmd_byte_count_in == 9'h000) ?
                        (cmd_no_stop_in ? SBI_HOLD : SBI_IDLE) : SBI_DATA;
          end else if (idx_en_r) begin
            state_nxt = SBI_IDX_HI;
          end else begin
            state_nxt = SBI_IDX_LO;
          end
        end
      end
      SBI_IDX_HI, SBI_IDX_LO, SBI_DATA: begin
        if (link_edge && !wait_data) begin
          bit_cnt_nxt = ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
          if (!ack_slot && tx_mode) begin
            sda_oe_nxt = 1'b1;
            if (bit_cnt_r == 4'h0) begin
              sda_out_nxt = tx_byte[7];
              shift_nxt   = {tx_byte[6:0], 1'b0};
            end else begin
              sda_out_nxt = shift_r[7];
              shift_nxt   = {shift_r[6:0], 1'b0};
            end
          end else if (!ack_slot) begin
            sda_oe_nxt = 1'b0;
            shift_nxt  = {shift_r[6:0], sda_s};
          end else if (tx_mode) begin
            sda_oe_nxt = 1'b0;
            if (sda_s) begin
              nak_set   = 1'b1;
              state_nxt = SBI_IDLE;
            end else if (state_r == SBI_IDX_HI) begin
              state_nxt = SBI_IDX_LO;
            end else if (state_r == SBI_IDX_LO) begin
              state_nxt = (bytes_left_r == 9'h000) ?
                          (no_stop_r ? SBI_HOLD : SBI_IDLE) : SBI_DATA;
            end else begin
              bytes_left_nxt = bytes_left_r - 9'h001;
              byte_sel_nxt   = byte_sel_r + 2'h1;
              if (word_end) begin
                word_valid_nxt = 1'b0;
              end
              if (last_byte) begin
                state_nxt = no_stop_r ? SBI_HOLD : SBI_IDLE;
              end
            end
          end else begin
            // Master acknowledges all but the last received byte
            sda_oe_nxt     = 1'b1;
            sda_out_nxt    = last_byte;
            bytes_left_nxt = bytes_left_r - 9'h001;
            byte_sel_nxt   = byte_sel_r + 2'h1;
            rword_nxt[{byte_sel_r, 3'h0} +: 8] = shift_r;
            if (word_end) begin
              data_rdata_nxt = rword_nxt;
              rvalid_nxt     = 1'b1;
              rword_nxt      = '0;
            end
            if (last_byte) begin
              state_nxt = no_stop_r ? SBI_HOLD : SBI_IDLE;
            end
          end
        end else if (!link_edge && !wait_data) begin
          // Waits on software are not the slave's stall
          stall_cnt_nxt = stall_cnt_r + 1'b1;
          if (stall_cnt_r == `SBI_STALL_CNT_W'(`SBI_STALL_CYC - 1)) begin
            stall_set  = 1'b1;
            sda_oe_nxt = 1'b0;
            state_nxt  = SBI_IDLE;
          end
        end
      end
      default: begin
        state_nxt  = SBI_IDLE;
        sda_oe_nxt = 1'b0;
      end
    endcase

    // Let go of the line on the fall before the slave's turn, or the
    // slot's rising edge would sample our own last bit
    if (busy && link_fall && (ack_slot ? tx_mode : !tx_mode)) begin
      sda_oe_nxt = 1'b0;
    end

    // Software clear aborts any transfer in flight
    if (software_clear_interrupt_in) begin
      state_nxt      = SBI_IDLE;
      sda_oe_nxt     = 1'b0;
      word_valid_nxt = 1'b0;
      load_pend_nxt  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mask_r   <= sbi_mask_t'(`SBI_IRQ_MASK_RESET);
      idx_en_r <= 1'b0;
      idx_r    <= 16'h0000;
    end else if (reg_wr_in && sel_mask) begin
      mask_r <= reg_wdata_in[`SBI_MASK_MSB:0];
    end else if (reg_wr_in && sel_idx) begin
      idx_en_r <= reg_wdata_in[`SBI_IDX_EN_BIT];
      idx_r    <= reg_wdata_in[`SBI_IDX_HI_MSB:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      rdata_r <= sel_mask ? {27'h0000000, mask_r} :
                 sel_idx  ? {idx_en_r, 15'h0000, idx_r} : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r      <= SBI_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      bytes_left_r <= 9'h000;
      byte_sel_r   <= 2'h0;
      cmd_idx_r    <= 8'h00;
      rd_mode_r    <= 1'b0;
      no_stop_r    <= 1'b0;
      word_r       <= 32'h0000_0000;
      word_valid_r <= 1'b0;
      load_pend_r  <= 1'b0;
      rword_r      <= 32'h0000_0000;
      rvalid_r     <= 1'b0;
      data_rdata_r <= 32'h0000_0000;
      sda_out_r    <= 1'b1;
      sda_oe_r     <= 1'b0;
      stall_cnt_r  <= '0;
      link_clk_d_r <= 1'b0;
      hardware_ready_flag_d_r    <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      shift_r      <= shift_nxt;
      bytes_left_r <= bytes_left_nxt;
      byte_sel_r   <= byte_sel_nxt;
      cmd_idx_r    <= cmd_idx_nxt;
      rd_mode_r    <= rd_mode_nxt;
      no_stop_r    <= no_stop_nxt;
      word_r       <= word_nxt;
      word_valid_r <= word_valid_nxt;
      load_pend_r  <= load_pend_nxt;
      rword_r      <= rword_nxt;
      rvalid_r     <= rvalid_nxt;
      data_rdata_r <= data_rdata_nxt;
      sda_out_r    <= sda_out_nxt;
      sda_oe_r     <= sda_oe_nxt;
      stall_cnt_r  <= stall_cnt_nxt;
      link_clk_d_r <= link_clk_s;
      hardware_ready_flag_d_r    <= hardware_ready_flag;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      nak_r        <= 1'b0;
      stall_r      <= 1'b0;
      irq_status_r <= 1'b0;
    end else begin
      nak_r        <= nak_set || (nak_r && !software_clear_interrupt_in);
      stall_r      <= stall_set || (stall_r && !software_clear_interrupt_in);
      irq_status_r <= irq_set ||
                      (irq_status_r && !software_clear_interrupt_in);
    end
  end

  assign reg_rdata_out           = rdata_r;
  assign data_wready_out         = fifo_in_ready;
  assign data_rdata_out          = data_rdata_r;
  assign sda_out                 = sda_out_r;
  assign sda_oe_out              = sda_oe_r;
  assign hardware_ready_flag_out = hardware_ready_flag;
  assign hold_phase_flag_out     = (state_r == SBI_HOLD);
  assign nak_flag_out            = nak_r;
  assign stall_flag_out          = stall_r;
  assign active_out              = (state_r != SBI_IDLE);
  assign irq_status_out          = irq_status_r;

endmodule // sbi_engine

/* sbi_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SBI_REGS_SVH
`define SBI_REGS_SVH

`define SBI_ADDR_W            20
`define SBI_IRQ_MASK_ADDR     20'hc5110
`define SBI_TWO_BYTE_IDX_ADDR 20'hc5120

`define SBI_IRQ_MASK_RESET    32'h0000_0000
`define SBI_TWO_BYTE_RESET    32'h0000_0000

`define SBI_MASK_MSB          4
`define SBI_MASK_STALL        4
`define SBI_MASK_NAK          3
`define SBI_MASK_IDLE         2
`define SBI_MASK_HOLD         1
`define SBI_MASK_HARDWARE_READY_FLAG        0

`define SBI_IDX_EN_BIT        31
`define SBI_IDX_HI_MSB        15
`define SBI_IDX_HI_LSB        8
`define SBI_IDX_LO_MSB        7

`define SBI_ACK_SLOT          4'h8
`define SBI_FIFO_DEPTH        16
`define SBI_WORD_W            32

`define SBI_CLK_PERIOD_NS     10
`define SBI_STALL_TIME_NS     20000
`define SBI_STALL_CYC \
  ((`SBI_STALL_TIME_NS + `SBI_CLK_PERIOD_NS - 1) / `SBI_CLK_PERIOD_NS)
`define SBI_STALL_CNT_W       12

`endif

/* sbi_pkg.sv */
// Types shared by the serial index and interrupt-mask block
package sbi_pkg;

  typedef enum logic [2:0] {
    SBI_IDLE,
    SBI_IDX_HI,
    SBI_IDX_LO,
    SBI_DATA,
    SBI_HOLD
  } sbi_state_e;

  typedef logic [4:0] sbi_mask_t;

endpackage : sbi_pkg

/* sbi_sync.sv */
// Two-flop synchroniser for a group of outside levels
module sbi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= async_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;

endmodule // sbi_sync

/* sbi_fifo.sv */
// Write-data FIFO; popped word appears in out_data_out one cycle later
module sbi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic [WIDTH-1:0] out_data_r;
  wire              full;
  wire              empty;
  wire              push;
  wire              pop;

  assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                 (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign push  = in_valid_in && !full;
  assign pop   = out_ready_in && !empty;

  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = out_data_r;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      out_data_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r   <= rd_ptr_r + 1'b1;
        out_data_r <= mem_r[rd_ptr_r[AW-1:0]];
      end
    end
  end

endmodule // sbi_fifo

/* sbi_engine_monitor.sv */
// Port-level checks for the serial index and interrupt-mask engine
`include "sbi_regs.svh"
module sbi_engine_monitor (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [19:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        software_clear_interrupt_in,
  input wire logic        hardware_ready_flag_out,
  input wire logic        hold_phase_flag_out,
  input wire logic        nak_flag_out,
  input wire logic        stall_flag_out,
  input wire logic        active_out,
  input wire logic        irq_status_out
);
  logic [4:0] mask_r;
  wire        mask_hit = reg_addr_in == `SBI_IRQ_MASK_ADDR;
  wire        idx_hit  = reg_addr_in == `SBI_TWO_BYTE_IDX_ADDR;
  wire        no_clr   = !software_clear_interrupt_in;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // Shadow of the mask so enables can be judged from the ports alone
  always_ff @(posedge sys_clk_in) begin
    if (rst_in)
      mask_r <= 5'h00;
    else if (reg_wr_in && mask_hit)
      mask_r <= reg_wdata_in[4:0];
  end

  sequence s_rd(logic hit);
    reg_rd_in && !reg_wr_in && hit;
  endsequence
  // Status may lag its event by a register stage or two
  sequence s_irq_up;
    ##[0:2] irq_status_out;
  endsequence

  property p_rd_mask;
    s_rd(mask_hit) |=> reg_rdata_out == {27'h0, $past(mask_r)};
  endproperty
  property p_rd_idx;
    s_rd(idx_hit) |=> reg_rdata_out[30:16] == 15'h0;
  endproperty
  property p_cause;
    $rose(irq_status_out) |-> $past(mask_r) != 5'h00;
  endproperty
  property p_clr;
    $fell(irq_status_out) |-> $past(software_clear_interrupt_in);
  endproperty
  property p_nak_keep;
    $fell(nak_flag_out) |-> $past(software_clear_interrupt_in);
  endproperty
  property p_stall;
    $rose(stall_flag_out) && mask_r[4] |-> s_irq_up;
  endproperty
  property p_nak;
    $rose(nak_flag_out) && mask_r[3] |-> s_irq_up;
  endproperty
  property p_idle;
    $fell(active_out) && mask_r[2] && no_clr && $past(no_clr) |-> s_irq_up;
  endproperty
  property p_hold;
    $rose(hold_phase_flag_out) && mask_r[1] |-> s_irq_up;
  endproperty
  property p_ready;
    $rose(hardware_ready_flag_out) && mask_r[0] && no_clr |-> s_irq_up;
  endproperty

  a_rd_mask: assert property (p_rd_mask)
    else $error("mask readback wrong");
  a_rd_idx: assert property (p_rd_idx)
    else $error("index reserved bits not zero");
  a_cause: assert property (p_cause)
    else $error("status set with mask clear");
  a_clr: assert property (p_clr)
    else $error("status dropped without clear");
  a_nak_keep: assert property (p_nak_keep)
    else $error("ack error dropped without clear");
  a_stall: assert property (p_stall)
    else $error("stall event did not set status");
  a_nak: assert property (p_nak)
    else $error("ack error did not set status");
  a_idle: assert property (p_idle)
    else $error("idle entry did not set status");
  a_hold: assert property (p_hold)
    else $error("hold entry did not set status");
  a_ready: assert property (p_ready)
    else $error("ready rise did not set status");
endmodule // sbi_engine_monitor

bind sbi_engine sbi_engine_monitor u_mon (
  .sys_clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
  .reg_rdata_out, .software_clear_interrupt_in, .hardware_ready_flag_out,
  .hold_phase_flag_out, .nak_flag_out, .stall_flag_out, .active_out,
  .irq_status_out
);

/* sbi_slave_model.sv */
// Behavioural two-wire slave: link clock, acknowledges and read bytes
module sbi_slave_model (
  input  wire logic       start_in,
  input  wire logic       run_in,
  input  wire logic       read_in,
  input  wire logic       nak_in,
  input  wire logic [1:0] hdr_in,
  input  wire logic [7:0] seed_in,
  input  wire logic       sda_out_in,
  input  wire logic       sda_oe_in,
  output logic            link_clk_out,
  output logic            sda_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt = 0;
  int         slot;
  int         byt;
  logic [7:0] sh;
  logic [7:0] dat;
  logic       drv;
  logic [7:0] got[$];

  assign slot = cnt % 9;
  assign byt  = cnt / 9;
  assign dat  = seed_in + 8'(byt - hdr_in);
  // Read bytes msb first; we release the ninth slot for the master
  assign drv = (read_in && byt >= hdr_in) ? (slot == 8 || dat[7 - slot])
                                          : (slot != 8 || nak_in);
  // Released line floats to the pull-up level
  assign sda_line_out = (sda_oe_in ? sda_out_in : 1'b1) & drv;

  always @(posedge start_in) cnt = 0;

  // Clock only runs within a frame; a pause keeps the bit position
  initial begin
    link_clk_out = 1'b0;
    forever begin
      if (run_in) begin
        #80 link_clk_out = 1'b1;
        #80 link_clk_out = 1'b0;
        if (sda_oe_in && slot < 8)
          sh = {sh[6:0], sda_out_in};
        if (sda_oe_in && slot == 7)
          got.push_back(sh);
        cnt++;
      end else
        #7;
    end
  end
endmodule // sbi_slave_model

/* tb_sbi_engine.sv */
// Self-checking bench for the serial index and interrupt-mask engine
`include "sbi_regs.svh"
module tb_sbi_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic [19:0] reg_addr_in = 0;
  logic [31:0] reg_wdata_in = 0, data_wdata_in = 0, reg_rdata_out;
  logic [31:0] data_rdata_out;
  logic        cmd_go_in = 0, cmd_read_in = 0, cmd_no_stop_in = 0;
  logic        cmd_index_en_in = 1, software_clear_interrupt_in = 0;
  logic        data_wr_in = 0, data_rd_in = 0, data_wready_out;
  logic [7:0]  cmd_index_in = 0, seed = 0;
  logic [8:0]  cmd_byte_count_in = 0;
  logic        link_clk_in, sda_in, sda_out, sda_oe_out;
  logic        hardware_ready_flag_out, hold_phase_flag_out, nak_flag_out;
  logic        stall_flag_out, active_out, irq_status_out;
  logic        run = 0, s_rd = 0, s_nak = 0;
  logic [1:0]  hdr = 1;
  logic [4:0]  mk;
  logic [7:0]  exp_q[$];
  int          fail_count = 0, compares = 0, cyc = 0;

  sbi_engine u_dut (
    .sys_clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .cmd_go_in, .cmd_read_in, .cmd_index_en_in, .cmd_index_in,
    .cmd_no_stop_in, .cmd_byte_count_in, .software_clear_interrupt_in,
    .data_wr_in, .data_wdata_in, .data_wready_out, .data_rd_in,
    .data_rdata_out, .link_clk_in, .sda_in, .sda_out, .sda_oe_out,
    .hardware_ready_flag_out, .hold_phase_flag_out, .nak_flag_out,
    .stall_flag_out, .active_out, .irq_status_out
  );
  sbi_slave_model u_slave (
    .start_in(cmd_go_in), .run_in(run), .read_in(s_rd), .nak_in(s_nak),
    .hdr_in(hdr), .seed_in(seed), .sda_out_in(sda_out),
    .sda_oe_in(sda_oe_out), .link_clk_out(link_clk_in), .sda_line_out(sda_in)
  );

  initial forever #5 sys_clk_in = ~sys_clk_in;

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(logic [19:0] a, logic [31:0] d);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    @(negedge sys_clk_in);
    reg_wr_in = 0;
  endtask

  task automatic rd_chk(logic [19:0] a, logic [31:0] exp);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1;
    tick(1);
    reg_rd_in = 0;
    tick(1);
    chk(reg_rdata_out, exp);
  endtask

  task automatic push_words(int n);
    logic [31:0] w;
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      @(negedge sys_clk_in);
      data_wdata_in = w;
      data_wr_in = 1;
      for (int b = 0; b < 4; b++)
        exp_q.push_back(w[8*b +: 8]);
    end
    @(negedge sys_clk_in);
    data_wr_in = 0;
  endtask

  // Kinds: 0 write, 1 write without stop, 2 refused ack, 3 read, 4 stall
  function automatic logic [4:0] ev_of(int k);
    case (k)
      0: return 5'h04;
      1: return 5'h02;
      2: return 5'h0c;
      3: return 5'h05;
      default: return 5'h14;
    endcase
  endfunction

  task automatic run_case(int k, int n, logic tw, logic [4:0] m, int pz);
    logic [15:0] idx;
    logic [7:0]  ci;
    idx = $urandom;
    ci = $urandom;
    seed = $urandom;
    exp_q.delete();
    u_slave.got.delete();
    reg_wr(`SBI_IRQ_MASK_ADDR, {27'h0, m});
    reg_wr(`SBI_TWO_BYTE_IDX_ADDR, {tw, 15'h0, idx});
    exp_q = {ci};
    if (tw)
      exp_q = {idx[15:8], idx[7:0]};
    hdr = tw ? 2'd2 : 2'd1;
    s_rd = k == 3;
    s_nak = k == 2;
    if (k < 2)
      push_words((n + 3) / 4);
    while (exp_q.size() > hdr + n)
      void'(exp_q.pop_back());
    chk(data_wready_out, (n + 3) / 4 < 16); // buffer room
    @(negedge sys_clk_in);
    cmd_read_in = s_rd;
    cmd_index_in = ci;
    cmd_no_stop_in = k == 1;
    cmd_byte_count_in = 9'(n);
    cmd_go_in = 1;
    @(negedge sys_clk_in);
    cmd_go_in = 0;
    run = k != 4;
    // end seen by idle or hold
    for (int i = 0; i < 25000; i++) begin
      @(negedge sys_clk_in);
      if (active_out !== 1'b1 || hold_phase_flag_out === 1'b1)
        break;
      if (!s_rd)
        chk(hardware_ready_flag_out, data_wready_out); // room only
      if (i == pz) begin
        run = 0;
        tick(1000);
        run = 1;
      end
    end
    chk(active_out & !hold_phase_flag_out, 1'b0); // ended in time
    run = 0;
    tick(4);
    chk(irq_status_out, |(m & ev_of(k))); // masked events
    chk(hold_phase_flag_out, k == 1); // hold entry
    chk(nak_flag_out, k == 2); // ack error
    chk(stall_flag_out, k == 4); // stall flag
    if (k != 2 && k != 4) begin
      chk(u_slave.got.size(), exp_q.size()); // byte count
      foreach (exp_q[i])
        chk(u_slave.got[i], exp_q[i]); // index and written bytes
    end
    if (k == 3)
      chk(data_rdata_out, {seed + 8'd3, seed + 8'd2, seed + 8'd1, seed});
    data_rd_in = k == 3;
    tick(1);
    data_rd_in = 0;
    reg_wr(`SBI_IRQ_MASK_ADDR, 32'h0);
    software_clear_interrupt_in = 1;
    tick(1);
    software_clear_interrupt_in = 0;
    tick(2);
    chk(irq_status_out, 1'b0); // clear works
  endtask

  initial begin
    void'($urandom(32'he7e1));
    tick(8);
    rst_in = 0;
    rd_chk(`SBI_IRQ_MASK_ADDR, `SBI_IRQ_MASK_RESET); // reset value
    rd_chk(`SBI_TWO_BYTE_IDX_ADDR, `SBI_TWO_BYTE_RESET); // reset value
    reg_wr(`SBI_IRQ_MASK_ADDR, '1);
    rd_chk(`SBI_IRQ_MASK_ADDR, 32'h1f); // five bits
    reg_wr(`SBI_TWO_BYTE_IDX_ADDR, '1);
    rd_chk(`SBI_TWO_BYTE_IDX_ADDR, 32'h8000ffff); // enable and index
    reg_wr(20'hc5114, '1);
    rd_chk(20'hc5114, 32'h0); // unmapped place
    for (int k = 0; k < 5; k++)
      for (int j = 0; j < 8; j++) begin
        mk = (j < 5) ? 5'h01 << j : (j == 5) ? 5'h00 : 5'($urandom);
        run_case(k, (k == 3) ? 4 : 1 + $urandom % 2, j[0], mk, -1);
      end
    // Full buffer, then drained while the slave pauses mid-frame
    run_case(0, 64, 1'b0, 5'h00, 3000);
    final_report();
  end
endmodule // tb_sbi_engine
